/* File: src/adcmc_regs.vh */
// adcmc_regs.vh: register offsets, field positions, reset values and timing counts
// for the converter mode control block; included by the top-level design file by bare name
`ifndef ADCMC_REGS_VH
`define ADCMC_REGS_VH
// word indices on the register bus; the byte address is four times the index
`define ADCMC_IDX_MODE0 16'h12b8
`define ADCMC_IDX_MODE1 16'h12b9
`define ADCMC_IDX_MODE2 16'h12ba
`define ADCMC_IDX_PORT 16'h12bb
`define ADCMC_IDX_RESULT 16'h12c0
`define ADCMC_IDX_RESULT_LAST 16'h12d7
// mode register 0 fields
`define ADCMC_M0_START 0
`define ADCMC_M0_REPEAT 1
`define ADCMC_M0_BUSY 6
`define ADCMC_M0_DONE 7
// mode register 1 fields
`define ADCMC_M1_VREF 7
`define ADCMC_M1_LSRUN 6
`define ADCMC_M1_RSV_HI 5
`define ADCMC_M1_RSV_LO 4
`define ADCMC_M1_CH_HI 3
`define ADCMC_M1_CH_LO 0
// mode register 2 fields
`define ADCMC_M2_SCAN 0
// reset values
`define ADCMC_M0_RST 8'h00
`define ADCMC_M1_RST 8'h00
`define ADCMC_M2_RST 8'h00
// converter figures
`define ADCMC_RES_BITS 10
`define ADCMC_NUM_CH 12
`define ADCMC_NUM_RES 24
// settle time per approximation step in ns and derived cycle count at 100 MHz
`define ADCMC_STEP_NS 100
`define ADCMC_CLK_NS 10
`define ADCMC_STEP_CYC ((`ADCMC_STEP_NS + `ADCMC_CLK_NS - 1) / `ADCMC_CLK_NS)
`endif

/* File: src/adcmc_result_mem.v */
// adcmc_result_mem.v: byte-wide result store, one high and one low byte per channel
// assumes a single clock; read data are registered
`timescale 1ns/1ps
module adcmc_result_mem #(
    parameter DEPTH = 24,
    parameter AW = 5
) (
    input wire clk_sys,
    input wire rst,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [7:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:DEPTH-1];
    integer i;

    // write port and registered read port
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= 8'h00;
        end
        else
        begin
            if (we)
                mem[waddr] <= wdata;
            rdata <= mem[raddr];
        end
    end
endmodule

/* File: src/adcmc_top.v */
// adcmc_top.v: mode control, successive approximation sequencer and results of a
// 10-bit, 12-input converter behind an APB slave.
// assumes clk_sys at 100 MHz, an external comparator answering on cmp_in, and
// analog pins that also read as digital levels on ain_dig.
// Contract
// R1: the converter makes a 10-bit result by successive approximation from one of twelve inputs.
// R2: every analog input pin can also be read as a plain digital input port bit.
// R3: software should see conversion stopped before entering a standby state.
// R4: three mode control registers govern converter operation.
// R5: results sit in 24 byte registers, a high and low byte per channel.
// R6: mode register 1 is 8-bit read/write, reset to zero, with reference, sleep run, zero and channel fields.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "adcmc_regs.vh"
module adcmc_top #(
    parameter NUM_CH = `ADCMC_NUM_CH,
    parameter RES_BITS = `ADCMC_RES_BITS,
    parameter STEP_CYC = `ADCMC_STEP_CYC
) (
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [11:0] ain_dig,
    input wire cmp_in,
    input wire light_sleep_state,
    output reg [9:0] dac_code,
    output reg [3:0] sample_ch,
    output reg ref_voltage_apply_o,
    output reg comparator_en
);
    localparam ST_IDLE = 2'd0;
    localparam ST_STEP = 2'd1;
    localparam ST_STORE_HI = 2'd2;
    localparam ST_STORE_LO = 2'd3;
    // highest channel number, cut to the width of the channel field
    localparam LAST_IDX = NUM_CH - 1;
    localparam [3:0] LAST_CH = LAST_IDX[3:0];

    reg [11:0] ain_s1_q;
    reg [11:0] ain_s2_q;
    reg cmp_s1_q;
    reg cmp_s2_q;
    reg [7:0] adc_mode_ctrl_zero_q;
    reg [7:0] adc_mode_ctrl_one_q;
    reg [7:0] adc_mode_ctrl_two_q;
    reg [1:0] state_q;
    reg [3:0] bit_q;
    reg [9:0] sar_q;
    reg [7:0] wait_q;
    reg [3:0] conv_ch_q;
    reg done_q;
    reg rd_pend_q;
    reg [31:0] rd_d;
    reg res_we;
    reg [4:0] res_waddr;
    reg [7:0] res_wdata;
    wire [7:0] res_rdata;
    wire [15:0] widx;
    wire setup;
    wire acc;
    wire hit_mode0;
    wire hit_mode1;
    wire hit_mode2;
    wire hit_port;
    wire hit_res;
    wire mapped;
    wire [15:0] res_off;
    wire [3:0] last_ch;
    wire ls_block;

    // address decode: one word per register, byte address four times the index
    // word index of the bus address
    assign widx = paddr[17:2];
    assign setup = psel & ~penable;
    assign acc = psel & penable & pready;
    assign hit_mode0 = (widx == `ADCMC_IDX_MODE0);
    assign hit_mode1 = (widx == `ADCMC_IDX_MODE1);
    assign hit_mode2 = (widx == `ADCMC_IDX_MODE2);
    assign hit_port = (widx == `ADCMC_IDX_PORT);
    assign hit_res = (widx >= `ADCMC_IDX_RESULT) && (widx <= `ADCMC_IDX_RESULT_LAST);
    assign mapped = hit_mode0 | hit_mode1 | hit_mode2 | hit_port | hit_res;
    assign res_off = widx - `ADCMC_IDX_RESULT;
    // channel encodings past the last input are clamped to it
    assign last_ch = (adc_mode_ctrl_one_q[3:0] > LAST_CH) ? LAST_CH : adc_mode_ctrl_one_q[3:0];
    // conversion halts in light sleep unless run-in-sleep is set
    assign ls_block = light_sleep_state & ~adc_mode_ctrl_one_q[`ADCMC_M1_LSRUN];

    // two-flop synchronisers for pin levels and comparator
    // both arrive asynchronously, so only the second stage is ever read
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ain_s1_q <= 12'h000;
            ain_s2_q <= 12'h000;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end
        else
        begin
            ain_s1_q <= ain_dig; // R2
            ain_s2_q <= ain_s1_q;
            cmp_s1_q <= cmp_in;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // result store: 24 bytes, high byte at even slot, low at odd
    adcmc_result_mem #(
        .DEPTH(`ADCMC_NUM_RES),
        .AW(5)
    ) u_res (
        .clk_sys(clk_sys),
        .rst(rst),
        .we(res_we),
        .waddr(res_waddr),
        .wdata(res_wdata),
        .raddr(res_off[4:0]),
        .rdata(res_rdata)
    ); // R5

    // apb slave: one wait state so registered memory data can be returned
    // read data are captured on the same edge that pready rises and held for that cycle
    // pslverr marks any address outside the map; writes there change nothing
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            rd_pend_q <= 1'b0;
        end
        else
        begin
            rd_pend_q <= setup;
            pready <= rd_pend_q & psel & penable & ~pready;
            pslverr <= rd_pend_q & psel & penable & ~pready & ~mapped;
            if (rd_pend_q & psel & penable & ~pready & ~pwrite)
                prdata <= rd_d;
            else
                prdata <= 32'h00000000;
        end
    end

    // read data mux
    always @*
    begin
        rd_d = 32'h00000000;
        if (hit_mode0)
        begin
            rd_d = {24'h000000, adc_mode_ctrl_zero_q};
            rd_d[`ADCMC_M0_DONE] = done_q; // live flag, cleared on the edge it is captured
        end
        else if (hit_mode1)
            rd_d = {24'h000000, adc_mode_ctrl_one_q};
        else if (hit_mode2)
            rd_d = {24'h000000, adc_mode_ctrl_two_q};
        else if (hit_port)
            rd_d = {20'h00000, ain_s2_q}; // R2
        else if (hit_res)
            rd_d = {24'h000000, res_rdata};
    end

    // mode registers and successive approximation sequencer
    // each step waits so the trial code has passed the output register, the
    // external comparator and its synchroniser before the bit is decided
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            adc_mode_ctrl_zero_q <= `ADCMC_M0_RST; // R4
            adc_mode_ctrl_one_q <= `ADCMC_M1_RST; // R6
            adc_mode_ctrl_two_q <= `ADCMC_M2_RST;
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            sar_q <= 10'h000;
            wait_q <= 8'h00;
            conv_ch_q <= 4'h0;
            done_q <= 1'b0;
            res_we <= 1'b0;
            res_waddr <= 5'h00;
            res_wdata <= 8'h00;
        end
        else
        begin
            res_we <= 1'b0;
            // software writes; reserved bits 5:4 of mode 1 always store zero
            if (acc & pwrite & ~pslverr)
            begin
                if (hit_mode0)
                    adc_mode_ctrl_zero_q[5:0] <= pwdata[5:0];
                if (hit_mode1)
                    adc_mode_ctrl_one_q <= {pwdata[7:6], 2'b00, pwdata[3:0]}; // R6
                if (hit_mode2)
                    adc_mode_ctrl_two_q <= pwdata[7:0];
            end
            // done flag: cleared as a read of mode 0 captures it, a new completion wins
            if (rd_pend_q & psel & penable & ~pready & ~pwrite & hit_mode0)
                done_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    // a start waits here while the reference is off or sleep blocks it
                    if (adc_mode_ctrl_zero_q[`ADCMC_M0_START] &
                        adc_mode_ctrl_one_q[`ADCMC_M1_VREF] & ~ls_block)
                    begin
                        state_q <= ST_STEP;
                        bit_q <= 4'd9;
                        sar_q <= 10'h200;
                        wait_q <= STEP_CYC[7:0];
                        conv_ch_q <= adc_mode_ctrl_two_q[`ADCMC_M2_SCAN] ? 4'h0 : last_ch;
                        adc_mode_ctrl_zero_q[`ADCMC_M0_START] <= 1'b0;
                    end
                end
                ST_STEP:
                begin
                    // an abort drops the partial code; nothing is stored, done is not raised
                    if (ls_block)
                        state_q <= ST_IDLE; // aborted: stop in light sleep
                    else if (wait_q != 8'h00)
                        wait_q <= wait_q - 8'h01;
                    else
                    begin
                        // keep or drop the trial bit, then try the next one R1
                        if (!cmp_s2_q)
                            sar_q[bit_q] <= 1'b0;
                        if (bit_q == 4'h0)
                            state_q <= ST_STORE_HI;
                        else
                        begin
                            sar_q[bit_q - 4'h1] <= 1'b1;
                            bit_q <= bit_q - 4'h1;
                            wait_q <= STEP_CYC[7:0];
                        end
                    end
                end
                ST_STORE_HI:
                begin
                    res_we <= 1'b1;
                    res_waddr <= {conv_ch_q, 1'b0};
                    res_wdata <= sar_q[9:2]; // R5
                    state_q <= ST_STORE_LO;
                end
                ST_STORE_LO:
                begin
                    res_we <= 1'b1;
                    res_waddr <= {conv_ch_q, 1'b1};
                    res_wdata <= {sar_q[1:0], 6'h00};
                    // the low byte completes the pair, so done is raised here
                    done_q <= 1'b1;
                    if (adc_mode_ctrl_two_q[`ADCMC_M2_SCAN] && conv_ch_q < last_ch)
                    begin
                        conv_ch_q <= conv_ch_q + 4'h1;
                        state_q <= ST_STEP;
                        bit_q <= 4'd9;
                        sar_q <= 10'h200;
                        wait_q <= STEP_CYC[7:0];
                    end
                    else if (adc_mode_ctrl_zero_q[`ADCMC_M0_REPEAT])
                    begin
                        conv_ch_q <= adc_mode_ctrl_two_q[`ADCMC_M2_SCAN] ? 4'h0 : last_ch;
                        state_q <= ST_STEP;
                        bit_q <= 4'd9;
                        sar_q <= 10'h200;
                        wait_q <= STEP_CYC[7:0];
                    end
                    else
                        state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
            // busy status lets software confirm a stop before standby
            adc_mode_ctrl_zero_q[`ADCMC_M0_BUSY] <= (state_q != ST_IDLE); // R3
        end
    end

    // analog front end drive, all registered
    // the comparator is enabled only while the sequencer runs, to save standby power
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            dac_code <= 10'h000;
            sample_ch <= 4'h0;
            ref_voltage_apply_o <= 1'b0;
            comparator_en <= 1'b0;
        end
        else
        begin
            dac_code <= sar_q; // R1
            sample_ch <= conv_ch_q;
            ref_voltage_apply_o <= adc_mode_ctrl_one_q[`ADCMC_M1_VREF]; // R6
            comparator_en <= (state_q != ST_IDLE);
        end
    end
endmodule

/* File: tb/adcmc_checker.sv */
// adcmc_checker.sv: bus timing and mode control properties of adcmc_top
// assumes it is bound to adcmc_top and sees only its ports
`timescale 1ns/1ps
module adcmc_checker #(
    parameter NUM_CH = 12
) (
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire light_sleep_state,
    input wire [3:0] sample_ch,
    input wire ref_voltage_apply_o,
    input wire comparator_en
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic m1_wr;
    logic lsrun_q;
    // completed write to mode register 1
    assign m1_wr = pready && psel && penable && pwrite && !pslverr && paddr == 18'h4ae4;
    // sleep-run bit as last written
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            lsrun_q <= 1'b0;
        else if (m1_wr)
            lsrun_q <= pwdata[6];
    end
    chk_ready_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("pready not after one wait state");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without pready");
    chk_rdata_upper: assert property (pready |-> prdata[31:12] == 20'h0)
        else $error("upper read data bits set");
    chk_vref_follow: assert property (m1_wr |-> ##2 ref_voltage_apply_o == $past(pwdata[7], 2))
        else $error("reference output differs from written bit");
    chk_ch_range: assert property (comparator_en |-> sample_ch < NUM_CH)
        else $error("channel out of range while converting");
    chk_sleep_stop: assert property (light_sleep_state && !lsrun_q |-> ##[1:4] !comparator_en)
        else $error("conversion runs in light sleep");
endmodule
bind adcmc_top adcmc_checker #(.NUM_CH(NUM_CH)) adcmc_checker_i (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .light_sleep_state(light_sleep_state),
    .sample_ch(sample_ch), .ref_voltage_apply_o(ref_voltage_apply_o),
    .comparator_en(comparator_en));

/* File: tb/adcmc_top_tb.sv */
// adcmc_top_tb.sv: self-checking bench for the converter mode control block
// assumes adcmc_top with its checker bound; the bench plays comparator and pins
`timescale 1ns/1ps
module adcmc_top_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [11:0] ain_dig = 12'h0;
    logic cmp_in = 1'b0;
    logic light_sleep_state = 1'b0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [9:0] dac_code;
    wire [3:0] sample_ch;
    wire ref_voltage_apply_o;
    wire comparator_en;
    logic [9:0] vin [16];
    logic [31:0] rd;
    logic err;
    logic [7:0] w;
    int errors = 0;
    int checks_done = 0;
    adcmc_top #(.STEP_CYC(4)) adcmc_top_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ain_dig(ain_dig), .cmp_in(cmp_in),
        .light_sleep_state(light_sleep_state), .dac_code(dac_code), .sample_ch(sample_ch),
        .ref_voltage_apply_o(ref_voltage_apply_o), .comparator_en(comparator_en));
    always #5 clk_sys = ~clk_sys;
    // comparator: high while the selected input sits at or above the trial code
    always @(posedge clk_sys)
        cmp_in <= (dac_code <= vin[sample_ch]);
    function automatic [31:0] res_hi(input [9:0] v);
        return {24'h0, v[9:2]};
    endfunction
    function automatic [31:0] res_lo(input [9:0] v);
        return {24'h0, v[1:0], 6'h00};
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; read data and error land in rd and err
    task apb(input [17:0] a, input logic wr, input [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // select channel, start, poll done, read both result bytes
    task convert(input int c, input [9:0] v, input logic run);
        int n;
        vin[c] = v;
        apb(18'h4ae4, 1'b1, {24'h0, 1'b1, run, 2'b00, 4'(c)});
        apb(18'h4ae0, 1'b1, 32'h1);
        n = 0;
        rd = 32'h0;
        while (rd[7] !== 1'b1 && n < 100)
        begin
            apb(18'h4ae0, 1'b0, 32'h0);
            n++;
        end
        chk("done", 32'h1, {31'h0, rd[7]});
        apb(18'(18'h4b00 + 8 * c), 1'b0, 32'h0);
        chk("result high", res_hi(v), rd);
        apb(18'(18'h4b04 + 8 * c), 1'b0, 32'h0);
        chk("result low", res_lo(v), rd);
    endtask
    // poll mode 0 until the busy bit drops, as software does before standby
    task wait_idle;
        int n;
        n = 0;
        rd = 32'h40;
        while (rd[6] !== 1'b0 && n < 400)
        begin
            apb(18'h4ae0, 1'b0, 32'h0);
            n++;
        end
        chk("busy", 32'h0, {31'h0, rd[6]});
    endtask
    task finish_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial
    begin
        #200us;
        errors++;
        finish_test;
    end
    // main sequence
    initial
    begin
        foreach (vin[i]) vin[i] = 10'h0;
        void'($urandom(96102));
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            apb(18'(18'h4ae0 + 4 * i), 1'b0, 32'h0);
            chk("mode reset", 32'h0, rd);
        end
        for (int i = 0; i < 10; i++)
        begin
            w = (i == 0) ? 8'hff : 8'($urandom);
            apb(18'h4ae4, 1'b1, {24'h0, w});
            apb(18'h4ae4, 1'b0, 32'h0);
            chk("mode1", {24'h0, w & 8'hcf}, rd);
            chk("vref pin", {31'h0, w[7]}, {31'h0, ref_voltage_apply_o});
        end
        repeat (4)
        begin
            ain_dig <= 12'($urandom);
            repeat (3) @(posedge clk_sys);
            apb(18'h4aec, 1'b0, 32'h0);
            chk("port", {20'h0, ain_dig}, rd);
        end
        apb(18'h3fff0, 1'b0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        convert(11, 10'h3ff, 1'b0);
        convert(0, 10'h000, 1'b0);
        repeat (4) convert($urandom_range(11), 10'($urandom), 1'b0);
        // scan from channel 0 up to the clamped last input
        foreach (vin[i]) vin[i] = 10'($urandom);
        apb(18'h4ae8, 1'b1, 32'h1);
        apb(18'h4ae4, 1'b1, 32'h8f);
        apb(18'h4ae0, 1'b1, 32'h1);
        wait_idle;
        for (int i = 0; i < 12; i++)
        begin
            apb(18'(18'h4b00 + 8 * i), 1'b0, 32'h0);
            chk("scan high", res_hi(vin[i]), rd);
            apb(18'(18'h4b04 + 8 * i), 1'b0, 32'h0);
            chk("scan low", res_lo(vin[i]), rd);
        end
        apb(18'h4ae8, 1'b1, 32'h0);
        // repeat keeps the sequencer busy past a completion until it is cleared
        vin[7] = 10'h1c6;
        apb(18'h4ae4, 1'b1, 32'h87);
        apb(18'h4ae0, 1'b1, 32'h3);
        repeat (80) @(posedge clk_sys);
        apb(18'h4ae0, 1'b0, 32'h0);
        chk("repeat busy", 32'h3, {30'h0, rd[7:6]});
        apb(18'h4ae0, 1'b1, 32'h0);
        wait_idle;
        apb(18'h4b38, 1'b0, 32'h0);
        chk("repeat high", res_hi(10'h1c6), rd);
        // light sleep in mid-conversion without run-in-sleep aborts it
        apb(18'h4ae4, 1'b1, 32'h83);
        apb(18'h4ae0, 1'b1, 32'h1);
        repeat (10) @(posedge clk_sys);
        light_sleep_state <= 1'b1;
        repeat (20) @(posedge clk_sys);
        apb(18'h4ae0, 1'b0, 32'h0);
        chk("sleep abort", 32'h0, {30'h0, rd[7:6]});
        convert(5, 10'h2a5, 1'b1);
        light_sleep_state <= 1'b0;
        finish_test;
    end
endmodule
